//--- bench/pin_logic_bench.sv
// Self-checking bench of the management pin logic
`timescale 1ns/1ps
module pin_logic_bench
	import pin_logic_pkg::*;
;
	logic clock, reset, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	pins_t p, pw;
	logic [1:0] adc_sel, gp_o, gp_oe, run_o, run_oe, chan_enable;
	logic scl_oe, sda_oe, alert_oe, sync_oe, irq, scl_w, sda_w, ack;
	int miscompares = 0, cmp_count = 0, cyc = 0, n;
	logic [15:0] rows [4] = '{16'h5335, 16'h5b30, 16'h53c5, 16'haec0};
	pin_logic #(.STUCK_NONBLK(2000), .STUCK_BLK(5000), .TELEM_LAT(400), .FAST_SLOT(50))
	u_pin_logic(.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_in(pw), .adc_result(linear_t'(16'he923)),
		.adc_sel(adc_sel), .scl_o(), .scl_oe(scl_oe), .sda_o(), .sda_oe(sda_oe),
		.alert_o(), .alert_oe(alert_oe), .gp_o(gp_o), .gp_oe(gp_oe), .run_o(run_o),
		.run_oe(run_oe), .sync_o(), .sync_oe(sync_oe), .chan_enable(chan_enable),
		.switch_tick(), .irq(irq));
	smbus_host u_smbus_host(.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl_w), .sda(sda_w));
	always_comb begin
		pw = p;
		pw.scl = scl_w;
		pw.sda = sda_w;
		pw.sync = ~sync_oe;
	end
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		// Look between edges, where the registered answer has settled
		do @(negedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		@(posedge clock);
		psel <= 0;
		penable <= 0;
	endtask
	task wt(input int k);
		repeat (k) @(posedge clock);
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			end_sim;
		end
	end
	initial begin
		reset = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h0;
		pwdata = 32'h0;
		p = '0;
		p.wp = 1;
		wt(4);
		chk("run_oe", 2'h3, run_oe);
		reset <= 0;
		wt(3);
		chk("run_oe", 2'h0, run_oe);
		for (int i = 0; i < 4; i++) begin
			{p.lo_code, p.lo_open, p.hi_code, p.hi_open} <= rows[i][15:7];
			wt(6);
			apb(1'h0, REG_STATUS, 32'h0);
			chk("own address", rows[i][6:0], rd[6:0]);
		end
		wt(500);
		apb(1'h0, REG_TELEM0, 32'h0);
		chk("telemetry", 16'he923, rd[15:0]);
		apb(1'h0, 8'h24, 32'h0);
		chk("unmapped error", 1'h1, er);
		p.run <= 2'h3;
		wt(1000);
		p.run <= 2'h0;
		wt(2100);
		chk("chan_enable", 2'h0, chan_enable);
		p.run <= 2'h3;
		wt(1990);
		chk("chan_enable", 2'h0, chan_enable);
		wt(40);
		chk("chan_enable", 2'h3, chan_enable);
		u_smbus_host.start;
		u_smbus_host.send(8'h90, ack);
		chk("foreign ack", 1'h1, ack);
		u_smbus_host.stop;
		u_smbus_host.start;
		u_smbus_host.send(8'h80, ack);
		chk("own ack", 1'h0, ack);
		wt(1500);
		apb(1'h0, REG_IRQ_STS, 32'h0);
		chk("early timeout", 1'h0, rd[EV_TIMEOUT]);
		wt(400);
		apb(1'h0, REG_IRQ_STS, 32'h0);
		chk("timeout", 1'h1, rd[EV_TIMEOUT]);
		chk("bus released", 2'h0, {scl_oe, sda_oe});
		chk("masked irq", 1'h0, irq);
		u_smbus_host.stop;
		apb(1'h1, REG_IRQ_CLR, 32'h8);
		apb(1'h1, REG_IRQ_EN, 32'h8);
		apb(1'h1, REG_CTRL, 32'h2);
		u_smbus_host.start;
		u_smbus_host.send(8'h80, ack);
		wt(3000);
		chk("early block timeout", 1'h0, irq);
		wt(2300);
		chk("block timeout", 1'h1, irq);
		chk("alert_oe", 1'h1, alert_oe);
		u_smbus_host.stop;
		apb(1'h1, REG_IRQ_CLR, 32'h8);
		wt(2);
		chk("cleared irq", 1'h0, irq);
		apb(1'h1, REG_CTRL, 32'hc8);
		wt(2);
		chk("gp_oe", 2'h3, gp_oe);
		wt(500);
		n = 0;
		repeat (400) begin
			@(posedge clock);
			n += sync_oe;
		end
		chk("sync low clocks", SYNC_PULSE_CYC, n);
		end_sim;
	end
endmodule // pin_logic_bench
bind pin_logic pin_logic_sva u_pin_logic_sva(.clock(clock), .reset(reset), .psel(psel),
	.penable(penable), .pready(pready), .pins_in(pins_in), .scl_o(scl_o),
	.alert_o(alert_o), .alert_oe(alert_oe), .gp_o(gp_o), .run_oe(run_oe),
	.sync_oe(sync_oe), .chan_enable(chan_enable), .irq(irq));

//--- bench/pin_logic_sva.sv
// Port assertions of the management pin logic
`timescale 1ns/1ps
module pin_logic_sva
	import pin_logic_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire pins_t pins_in,
	input wire logic scl_o,
	input wire logic alert_o,
	input wire logic alert_oe,
	input wire logic [1:0] gp_o,
	input wire logic [1:0] run_oe,
	input wire logic sync_oe,
	input wire logic [1:0] chan_enable,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	int sync_run_q;
	int run_st_q;
	logic [1:0] run_prev_q;
	// Raw run stability, so the filter is judged from the pins
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync_run_q <= 0;
			run_st_q <= 0;
			run_prev_q <= 2'h0;
		end else begin
			sync_run_q <= sync_oe ? sync_run_q + 1 : 0;
			run_prev_q <= pins_in.run;
			run_st_q <= (pins_in.run != run_prev_q) ? 0 : run_st_q + 1;
		end
	end
	property p_run_hold;
		@(posedge clock) disable iff (1'b0) reset |-> run_oe == 2'h3;
	endproperty
	a_run_hold: assert property (p_run_hold)
		else $error("run pins not held low in reset");
	property p_run_free;
		$fell(reset) |=> run_oe == 2'h0;
	endproperty
	a_run_free: assert property (p_run_free)
		else $error("run pins not released");
	property p_alert;
		alert_oe == irq && !alert_o;
	endproperty
	a_alert: assert property (p_alert)
		else $error("alert pin does not follow irq");
	property p_scl;
		!scl_o;
	endproperty
	a_scl: assert property (p_scl)
		else $error("clock line driven high");
	property p_gp;
		gp_o == 2'h0;
	endproperty
	a_gp: assert property (p_gp)
		else $error("general pin driven high");
	property p_sync;
		$fell(sync_oe) |-> sync_run_q == SYNC_PULSE_CYC;
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync pulse of wrong length");
	property p_chan;
		$changed(chan_enable) |-> run_st_q >= RUN_FILT_CYC;
	endproperty
	a_chan: assert property (p_chan)
		else $error("channel enable changed before filter time");
	property p_ready;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("bus answer late");
endmodule // pin_logic_sva

//--- bench/smbus_host.sv
// Behavioural host on the two-wire management bus
`timescale 1ns/1ps
module smbus_host(
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic scl_low = 0;
	logic sda_low = 0;
	// Pull-ups give the idle high level
	assign scl = ~(scl_low | scl_oe);
	assign sda = ~(sda_low | sda_oe);
	task automatic pulse(input logic b, output logic s);
		sda_low = ~b;
		#31;
		scl_low = 0;
		wait (scl === 1'b1);
		#62;
		s = sda;
		scl_low = 1;
		#32;
	endtask
	task start;
		sda_low = 1;
		#62;
		scl_low = 1;
		#31;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(b[i], s);
		pulse(1'b1, ack);
	endtask
	task stop;
		sda_low = 1;
		#31;
		scl_low = 0;
		#62;
		sda_low = 0;
		#62;
	endtask
endmodule // smbus_host

//--- hdl/pin_logic.sv
// Serial management target and surrounding digital pin logic
`timescale 1ns/1ps
module pin_logic
	import pin_logic_pkg::*;
#(
	parameter int STUCK_NONBLK = STUCK_NONBLK_CYC,
	parameter int STUCK_BLK = STUCK_BLK_CYC,
	parameter int TELEM_LAT = TELEM_LAT_CYC,
	parameter int FAST_SLOT = FAST_SLOT_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pins_t pins_in,
	input wire linear_t adc_result,
	output logic [1:0] adc_sel,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	output logic alert_o,
	output logic alert_oe,
	output logic [1:0] gp_o,
	output logic [1:0] gp_oe,
	output logic [1:0] run_o,
	output logic [1:0] run_oe,
	output logic sync_o,
	output logic sync_oe,
	output logic [1:0] chan_enable,
	output logic switch_tick,
	output logic irq
);
	typedef struct packed {
		pins_t s1;
		pins_t s2;
		pins_t prev;
		logic [NUM_FILT-1:0] flt_lvl;
		logic [NUM_FILT-1:0][FILT_W-1:0] flt_cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		ctrl_t ctrl;
		logic [6:0] addr_nvm;
		logic [7:0] rx_data;
		logic [7:0] tx_data;
		logic pending;
		logic [EV_W-1:0] irq_sts;
		logic [EV_W-1:0] irq_en;
		logic irq;
		i2c_state_t st;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic first_byte;
		logic nack;
		logic sda_oe;
		logic scl_oe;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] slot;
		logic [1:0] tidx;
		logic [NUM_TELEM-1:0][15:0] telem;
		logic [15:0] sw_period;
		logic [15:0] sw_cnt;
		logic [FILT_W-1:0] watch;
		logic sync_oe;
		logic tick;
		logic [1:0] run_oe;
		logic low;
	} state_t;

	state_t q, d;
	logic scl_rise, scl_fall, start_c, stop_c, ext_edge, access, commit, wr, rd_ok;
	logic [EV_W-1:0] ev, clr;
	logic [6:0] own;
	logic [TMR_W-1:0] lim, slot_lim;
	logic [FILT_W-1:0] flim;
	logic [NUM_FILT-1:0] flt_in;
	logic [31:0] rdv;
	logic [1:0] tsel;

	always_comb begin
		d = q;
		ev = '0;
		clr = '0;
		rdv = '0;
		rd_ok = 1'b1;
		flim = '0;
		tsel = '0;
		d.s1 = pins_in;
		d.s2 = q.s1;
		d.prev = q.s2;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		d.tick = 1'b0;
		d.low = 1'b0;
		// Reset holds the pins low, release afterwards
		// run release
		d.run_oe = 2'b00;
		scl_rise = q.s2.scl & ~q.prev.scl;
		scl_fall = ~q.s2.scl & q.prev.scl;
		start_c = q.s2.scl & q.prev.scl & q.prev.sda & ~q.s2.sda;
		stop_c = q.s2.scl & q.prev.scl & ~q.prev.sda & q.s2.sda;

		flt_in = {q.s2.run, q.s2.gp};
		for (int i = 0; i < NUM_FILT; i++) begin
			flim = (i < 2) ? FILT_W'(GP_FILT_CYC - 1) : FILT_W'(RUN_FILT_CYC - 1);
			if (flt_in[i] == q.flt_lvl[i]) begin
				d.flt_cnt[i] = '0;
			end else if (q.flt_cnt[i] >= flim) begin
				d.flt_lvl[i] = flt_in[i];
				d.flt_cnt[i] = '0;
			end else begin
				d.flt_cnt[i] = q.flt_cnt[i] + 1'b1;
			end
		end

		own[3:0] = q.s2.lo_open ? q.addr_nvm[3:0] : q.s2.lo_code;
		own[6:4] = q.s2.hi_open ? q.addr_nvm[6:4] : q.s2.hi_code;

		// Register reads answer one cycle into the access phase
		access = psel & penable;
		commit = access & q.pready;
		wr = commit & pwrite;
		if (paddr[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (paddr >= REG_TELEM0 && paddr < REG_TELEM0 + TELEM_SPAN) begin
			tsel = paddr[3:2];
			rdv = {16'h0000, q.telem[tsel]};
		end else begin
			unique case (paddr)
				REG_CTRL: rdv = {24'h000000, q.ctrl};
				REG_STATUS: rdv = {18'h00000, q.st != ST_IDLE, q.s2.wp, q.flt_lvl[1:0],
					q.flt_lvl[3:2], q.watch != '0, own};
				REG_ADDR_NVM: rdv = {25'h0000000, q.addr_nvm};
				REG_RXDATA: rdv = {24'h000000, q.rx_data};
				REG_TXDATA: rdv = {24'h000000, q.tx_data};
				REG_IRQ_STS: rdv = {27'h0000000, q.irq_sts};
				REG_IRQ_CLR: rdv = '0;
				REG_IRQ_EN: rdv = {27'h0000000, q.irq_en};
				REG_SW_PERIOD: rdv = {16'h0000, q.sw_period};
				default: rd_ok = 1'b0;
			endcase
		end
		if (access & ~q.pready) begin
			d.pready = 1'b1;
			d.pslverr = ~rd_ok;
			d.prdata = rd_ok ? rdv : '0;
		end
		if (wr & rd_ok) begin
			unique case (paddr)
				REG_CTRL: d.ctrl = pwdata[7:0];
				REG_ADDR_NVM: d.addr_nvm = pwdata[6:0];
				REG_TXDATA: begin
					d.tx_data = pwdata[7:0];
					d.pending = 1'b0;
				end
				REG_IRQ_CLR: clr = pwdata[EV_W-1:0];
				REG_IRQ_EN: d.irq_en = pwdata[EV_W-1:0];
				REG_SW_PERIOD: d.sw_period = pwdata[15:0];
				default: ;
			endcase
		end
		if (commit & ~pwrite & paddr == REG_RXDATA) begin
			d.pending = 1'b0;
		end

		// Serial target; bus is sampled, never clocked by SCL
		if (scl_rise && q.cnt < 4'h8 && (q.st == ST_ADDR || q.st == ST_WRITE)) begin
			d.sh = {q.sh[6:0], q.s2.sda};
			d.cnt = q.cnt + 1'b1;
		end
		unique case (q.st)
			ST_ADDR: if (scl_fall && q.cnt == 4'h8) begin
				if (q.sh[7:1] == own) begin
					d.st = ST_ADDR_ACK;
					d.sda_oe = 1'b1;
					d.nack = q.sh[0];
				end else begin
					d.st = ST_IGNORE;
				end
			end
			ST_ADDR_ACK: if (scl_fall) begin
				d.cnt = '0;
				if (q.nack) begin
					d.st = ST_READ;
					d.sh = q.tx_data;
					d.sda_oe = ~q.tx_data[7];
				end else begin
					d.st = ST_WRITE;
					d.sda_oe = 1'b0;
					d.first_byte = 1'b1;
				end
			end
			ST_WRITE: if (scl_fall && q.cnt == 4'h8) begin
				d.rx_data = q.sh;
				d.first_byte = 1'b0;
				d.st = ST_WR_ACK;
				// only the command byte under protect
				d.sda_oe = ~(q.s2.wp & ~q.first_byte);
				d.pending = 1'b1;
				ev[EV_RX] = 1'b1;
			end
			ST_WR_ACK: if (scl_fall) begin
				d.sda_oe = 1'b0;
				d.cnt = '0;
				d.st = q.sda_oe ? ST_WRITE : ST_IGNORE;
			end
			ST_READ: begin
				if (scl_rise) begin
					d.cnt = q.cnt + 1'b1;
				end
				if (scl_fall && q.cnt == 4'h8) begin
					d.sda_oe = 1'b0;
					d.st = ST_RD_ACK;
					d.pending = 1'b1;
					ev[EV_TX] = 1'b1;
				end else if (scl_fall) begin
					d.sh = {q.sh[6:0], 1'b0};
					d.sda_oe = ~q.sh[6];
				end
			end
			ST_RD_ACK: begin
				if (scl_rise) begin
					d.nack = q.s2.sda;
				end
				if (scl_fall) begin
					d.cnt = '0;
					d.st = q.nack ? ST_IGNORE : ST_READ;
					d.sh = q.tx_data;
					d.sda_oe = ~q.nack & ~q.tx_data[7];
				end
			end
			default: ;
		endcase
		// stretch only pulls low, while a byte awaits software
		d.scl_oe = q.ctrl.stretch_en & d.pending & q.st != ST_IDLE &
			(q.scl_oe | ~q.s2.scl);

		lim = q.ctrl.block_read ? TMR_W'(STUCK_BLK - 1) : TMR_W'(STUCK_NONBLK - 1);
		if (q.st != ST_IDLE) begin
			d.tmr = q.tmr + 1'b1;
		end
		if (start_c) begin
			d.st = ST_ADDR;
			d.cnt = '0;
			d.tmr = '0;
			d.sda_oe = 1'b0;
		end else if (stop_c) begin
			d.st = ST_IDLE;
			d.sda_oe = 1'b0;
			ev[EV_STOP] = 1'b1;
		end else if (q.st != ST_IDLE && q.tmr >= lim) begin
			d.st = ST_IDLE;
			d.sda_oe = 1'b0;
			d.scl_oe = 1'b0;
			d.pending = 1'b0;
			ev[EV_TIMEOUT] = 1'b1;
		end

		slot_lim = q.ctrl.fast_sample ? TMR_W'(FAST_SLOT - 1) : TMR_W'(TELEM_LAT / NUM_TELEM - 1);
		d.slot = q.slot + 1'b1;
		if (q.slot >= slot_lim) begin
			d.slot = '0;
			d.telem[q.tidx] = pack_linear(adc_result);
			d.tidx = q.ctrl.fast_sample ? q.ctrl.fast_sel : q.tidx + 1'b1;
			ev[EV_CONV] = 1'b1;
		end

		// external falling edge restarts the period
		ext_edge = ~q.s2.sync & q.prev.sync & ~q.sync_oe;
		if (ext_edge) begin
			d.watch = FILT_W'(SYNC_WATCH_CYC);
		end else if (q.watch != '0) begin
			d.watch = q.watch - 1'b1;
		end
		if (ext_edge || q.sw_cnt >= q.sw_period - 1'b1) begin
			d.sw_cnt = '0;
			d.tick = 1'b1;
		end else begin
			d.sw_cnt = q.sw_cnt + 1'b1;
		end
		// pulse at each period start, except within SYNC_WATCH_CYC clocks of an external edge
		// Starts only at a period start, so enabling never gives a short pulse
		d.sync_oe = q.ctrl.sync_out_en & (q.watch == '0) &
			(d.sw_cnt < 16'(SYNC_PULSE_CYC)) & (q.sync_oe | d.sw_cnt == '0);

		// Set wins over a clear in the same cycle
		d.irq_sts = (q.irq_sts & ~clr) | ev;
		d.irq = |(d.irq_sts & d.irq_en);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.addr_nvm <= ADDR_NVM_RST;
			q.sw_period <= SW_PERIOD_RST;
			q.st <= ST_IDLE;
			q.run_oe <= 2'b11;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign adc_sel = q.tidx;
	assign scl_o = q.low;
	assign scl_oe = q.scl_oe;
	assign sda_o = q.low;
	assign sda_oe = q.sda_oe;
	// alert pulls low while interrupt stands
	assign alert_o = q.low;
	assign alert_oe = q.irq;
	// general pins pull low on request
	assign gp_o = {q.low, q.low};
	assign gp_oe = q.ctrl.gp_pull;
	assign run_o = {q.low, q.low};
	assign run_oe = q.run_oe;
	assign sync_o = q.low;
	assign sync_oe = q.sync_oe;
	assign chan_enable = q.flt_lvl[3:2];
	assign switch_tick = q.tick;
	assign irq = q.irq;
endmodule // pin_logic

//--- hdl/pin_logic_pkg.sv
// Constants, register map and carrier types of the management pin logic
package pin_logic_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CLK_KHZ = 200000;
	localparam int GP_FILT_NS = 3000;
	localparam int RUN_FILT_NS = 10000;
	localparam int SYNC_PULSE_NS = 500;
	localparam int SYNC_WATCH_NS = 5000;
	localparam int STUCK_NONBLK_MS = 32;
	localparam int STUCK_BLK_MS = 150;
	localparam int TELEM_LAT_MS = 90;
	localparam int FAST_SLOT_MS = 1;
	// Least times round up
	localparam int GP_FILT_CYC = (GP_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RUN_FILT_CYC = (RUN_FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SYNC_WATCH_CYC = (SYNC_WATCH_NS * 1000) / CLK_PERIOD_PS;
	localparam int STUCK_NONBLK_CYC = STUCK_NONBLK_MS * CLK_KHZ;
	localparam int STUCK_BLK_CYC = STUCK_BLK_MS * CLK_KHZ;
	localparam int TELEM_LAT_CYC = TELEM_LAT_MS * CLK_KHZ;
	localparam int FAST_SLOT_CYC = FAST_SLOT_MS * CLK_KHZ;
	localparam int FILT_W = 11;
	localparam int TMR_W = 25;
	localparam int NUM_TELEM = 4;
	localparam int NUM_FILT = 4;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADDR_NVM = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0c;
	localparam logic [7:0] REG_TXDATA = 8'h10;
	localparam logic [7:0] REG_IRQ_STS = 8'h14;
	localparam logic [7:0] REG_IRQ_CLR = 8'h18;
	localparam logic [7:0] REG_IRQ_EN = 8'h1c;
	localparam logic [7:0] REG_SW_PERIOD = 8'h20;
	localparam logic [7:0] REG_TELEM0 = 8'h30;
	localparam logic [7:0] TELEM_SPAN = 8'h10;

	localparam logic [6:0] ADDR_NVM_RST = 7'h40;
	localparam logic [15:0] SW_PERIOD_RST = 16'h0190;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Event bits of the interrupt status
	localparam int EV_RX = 0;
	localparam int EV_TX = 1;
	localparam int EV_STOP = 2;
	localparam int EV_TIMEOUT = 3;
	localparam int EV_CONV = 4;
	localparam int EV_W = 5;

	typedef struct packed {
		logic [1:0] gp_pull;
		logic [1:0] fast_sel;
		logic sync_out_en;
		logic fast_sample;
		logic block_read;
		logic stretch_en;
	} ctrl_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic sync;
		logic [1:0] gp;
		logic [1:0] run;
		logic wp;
		logic [3:0] lo_code;
		logic lo_open;
		logic [2:0] hi_code;
		logic hi_open;
	} pins_t;

	typedef struct packed {
		logic signed [4:0] exponent;
		logic signed [10:0] mantissa;
	} linear_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WR_ACK, ST_READ, ST_RD_ACK, ST_IGNORE
	} i2c_state_t;

	function automatic logic [15:0] pack_linear(input linear_t v);
		return {v.exponent, v.mantissa};
	endfunction
endpackage
